// file: core/dual_data_space_addressing.sv
// dual X/Y data space address generation and RAM access paths
`timescale 1ns/1ps
`default_nettype none
`include "dds_params.svh"

module dual_data_space_addressing #(
   parameter int ADDR_W = `DDS_ADDR_W,
   parameter int DATA_W = `DDS_DATA_W,
   parameter int REV_BITS = `DDS_REV_BITS,
   parameter logic [ADDR_W-1:0] Y_BASE = `DDS_Y_BASE
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // request from the pipeline
   input wire dds_pkg::op_t reqOp,
   input wire logic reqByte,
   input wire logic reqBitRev,
   input wire logic [ADDR_W-1:0] xAddr,
   input wire logic [ADDR_W-1:0] yAddr,
   input wire logic [DATA_W-1:0] wrData,
   // address generator modify and modulo setup
   input wire logic [ADDR_W-1:0] xStep,
   input wire logic [ADDR_W-1:0] yStep,
   input wire logic xModEn,
   input wire logic [ADDR_W-1:0] xModStart,
   input wire logic [ADDR_W-1:0] xModEnd,
   input wire logic yModEn,
   input wire logic [ADDR_W-1:0] yModStart,
   input wire logic [ADDR_W-1:0] yModEnd,
   // X bank port
   output logic [ADDR_W-2:0] xRamAddr,
   output logic xRamRd,
   output logic xRamWr,
   output logic [1:0] xRamBe,
   output logic [DATA_W-1:0] xRamWdata,
   input wire logic [DATA_W-1:0] xRamRdata,
   // Y bank port
   output logic [ADDR_W-2:0] yRamAddr,
   output logic yRamRd,
   output logic yRamWr,
   output logic [1:0] yRamBe,
   output logic [DATA_W-1:0] yRamWdata,
   input wire logic [DATA_W-1:0] yRamRdata,
   // results to the pipeline
   output logic [DATA_W-1:0] xReadData,
   output logic [DATA_W-1:0] yReadData,
   output logic rdValid,
   output logic dualValid,
   output logic [ADDR_W-1:0] xNextPtr,
   output logic [ADDR_W-1:0] yNextPtr,
   output logic spaceErr
);

   // ****************************************
   // address generators
   // ****************************************
   logic [REV_BITS-1:0] revIdx;
   logic [ADDR_W-1:0] xRevAddr;
   logic [ADDR_W-1:0] xSum;
   logic [ADDR_W-1:0] ySum;

   genvar g;
   generate
      for (g = 0; g < REV_BITS; g++)
      begin : g_rev
         assign revIdx[g] = xAddr[REV_BITS - g];
      end
   endgenerate

   // index sits above bit 0 so the mirror works on words, not bytes
   assign xRevAddr = {xAddr[ADDR_W-1:REV_BITS+1], revIdx, xAddr[0]};
   assign xSum = xAddr + xStep;
   assign ySum = yAddr + yStep;

   // ****************************************
   // access stage
   // ****************************************
   logic [ADDR_W-2:0] xRamAddr_q, xRamAddr_d, yRamAddr_q, yRamAddr_d;
   logic xRamRd_q, xRamRd_d, xRamWr_q, xRamWr_d;
   logic yRamRd_q, yRamRd_d, yRamWr_q, yRamWr_d;
   logic [1:0] xRamBe_q, xRamBe_d, yRamBe_q, yRamBe_d;
   logic [DATA_W-1:0] xRamWdata_q, xRamWdata_d, yRamWdata_q, yRamWdata_d;
   logic [ADDR_W-1:0] xNextPtr_q, xNextPtr_d, yNextPtr_q, yNextPtr_d;
   logic spaceErr_q, spaceErr_d;
   // read return steering, held for the data cycle
   logic pend_q, pend_d, pendDual_q, pendDual_d, fromY_q, fromY_d;
   logic [1:0] lane_q, lane_d;
   logic [ADDR_W-1:0] eff;
   logic [1:0] be;
   logic inY;

   always_comb
   begin
      {xRamAddr_d, yRamAddr_d} = {xRamAddr_q, yRamAddr_q};
      {xRamWdata_d, yRamWdata_d} = {xRamWdata_q, yRamWdata_q};
      {xRamRd_d, xRamWr_d, yRamRd_d, yRamWr_d} = 4'h0;
      {xRamBe_d, yRamBe_d} = {`DDS_BE_NONE, `DDS_BE_NONE};
      {pend_d, pendDual_d, fromY_d, spaceErr_d} = 4'h0;
      lane_d = `DDS_BE_WORD;
      eff = xAddr;
      // bit reversal only ever reaches X-space writes
      if ((reqOp == dds_pkg::OP_WRITE) && reqBitRev && (xAddr < Y_BASE))
      begin
         eff = xRevAddr;
      end
      inY = (eff >= Y_BASE);
      be = reqByte ? (eff[0] ? `DDS_BE_HI : `DDS_BE_LO) : `DDS_BE_WORD;
      // modulo wrap on reaching the end of the buffer
      xNextPtr_d = (xModEn && (xAddr == xModEnd)) ? xModStart : xSum;
      yNextPtr_d = (yModEn && (yAddr == yModEnd)) ? yModStart : ySum;
      if (reqOp == dds_pkg::OP_IDLE)
      begin
         xNextPtr_d = xNextPtr_q;
         yNextPtr_d = yNextPtr_q;
      end
      case (reqOp)
         dds_pkg::OP_READ:
         begin
            // combined space: bank picked by the fixed boundary
            pend_d = 1'b1;
            lane_d = be;
            fromY_d = inY;
            if (inY)
            begin
               yRamRd_d = 1'b1;
               yRamBe_d = be;
               yRamAddr_d = eff[ADDR_W-1:1];
            end
            else
            begin
               xRamRd_d = 1'b1;
               xRamBe_d = be;
               xRamAddr_d = eff[ADDR_W-1:1];
            end
         end
         dds_pkg::OP_WRITE:
         begin
            // writes use the combined space, never a separate Y view
            if (inY)
            begin
               yRamWr_d = 1'b1;
               yRamBe_d = be;
               yRamAddr_d = eff[ADDR_W-1:1];
               yRamWdata_d = wrData;
            end
            else
            begin
               xRamWr_d = 1'b1;
               xRamBe_d = be;
               xRamAddr_d = eff[ADDR_W-1:1];
               xRamWdata_d = wrData;
            end
         end
         dds_pkg::OP_DUAL:
         begin
            // separate spaces: both banks read in the same cycle
            xRamRd_d = 1'b1;
            yRamRd_d = 1'b1;
            xRamBe_d = `DDS_BE_WORD;
            yRamBe_d = `DDS_BE_WORD;
            xRamAddr_d = xAddr[ADDR_W-1:1];
            yRamAddr_d = yAddr[ADDR_W-1:1];
            pendDual_d = 1'b1;
            // operands outside their own space are flagged, not rerouted
            spaceErr_d = (xAddr >= Y_BASE) || (yAddr < Y_BASE);
         end
         default: xRamRd_d = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         {xRamAddr_q, yRamAddr_q, xRamWdata_q, yRamWdata_q} <= '0;
         {xRamRd_q, xRamWr_q, yRamRd_q, yRamWr_q} <= 4'h0;
         {xRamBe_q, yRamBe_q} <= {`DDS_BE_NONE, `DDS_BE_NONE};
         {xNextPtr_q, yNextPtr_q} <= '0;
         {spaceErr_q, pend_q, pendDual_q, fromY_q} <= 4'h0;
         lane_q <= `DDS_BE_WORD;
      end
      else
      begin
         {xRamAddr_q, yRamAddr_q} <= {xRamAddr_d, yRamAddr_d};
         {xRamWdata_q, yRamWdata_q} <= {xRamWdata_d, yRamWdata_d};
         {xRamRd_q, xRamWr_q, yRamRd_q, yRamWr_q} <= {xRamRd_d, xRamWr_d, yRamRd_d, yRamWr_d};
         {xRamBe_q, yRamBe_q} <= {xRamBe_d, yRamBe_d};
         {xNextPtr_q, yNextPtr_q} <= {xNextPtr_d, yNextPtr_d};
         {spaceErr_q, pend_q, pendDual_q, fromY_q} <= {spaceErr_d, pend_d, pendDual_d, fromY_d};
         lane_q <= lane_d;
      end
   end

   // ****************************************
   // read return stage
   // ****************************************
   logic [DATA_W-1:0] xReadData_q, xReadData_d, yReadData_q, yReadData_d, src;
   logic rdValid_q, rdValid_d, dualValid_q, dualValid_d;

   always_comb
   begin
      xReadData_d = xReadData_q;
      yReadData_d = yReadData_q;
      src = fromY_q ? yRamRdata : xRamRdata;
      rdValid_d = pend_q;
      dualValid_d = pendDual_q;
      if (pend_q)
      begin
         // a byte comes back in the low lane, upper byte zero
         if (lane_q == `DDS_BE_HI)
         begin
            xReadData_d = {{(DATA_W-`DDS_BYTE_W){1'b0}}, src[DATA_W-1:`DDS_BYTE_W]};
         end
         else if (lane_q == `DDS_BE_LO)
         begin
            xReadData_d = {{(DATA_W-`DDS_BYTE_W){1'b0}}, src[`DDS_BYTE_W-1:0]};
         end
         else
         begin
            xReadData_d = src;
         end
      end
      if (pendDual_q)
      begin
         xReadData_d = xRamRdata;
         yReadData_d = yRamRdata;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         {xReadData_q, yReadData_q} <= '0;
         {rdValid_q, dualValid_q} <= 2'h0;
      end
      else
      begin
         {xReadData_q, yReadData_q} <= {xReadData_d, yReadData_d};
         {rdValid_q, dualValid_q} <= {rdValid_d, dualValid_d};
      end
   end

   assign {xRamAddr, yRamAddr} = {xRamAddr_q, yRamAddr_q};
   assign {xRamRd, xRamWr, yRamRd, yRamWr} = {xRamRd_q, xRamWr_q, yRamRd_q, yRamWr_q};
   assign {xRamBe, yRamBe} = {xRamBe_q, yRamBe_q};
   assign {xRamWdata, yRamWdata} = {xRamWdata_q, yRamWdata_q};
   assign {xReadData, yReadData} = {xReadData_q, yReadData_q};
   assign {rdValid, dualValid, spaceErr} = {rdValid_q, dualValid_q, spaceErr_q};
   assign {xNextPtr, yNextPtr} = {xNextPtr_q, yNextPtr_q};

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   property p_dualBoth;
      reqOp == dds_pkg::OP_DUAL |=> xRamRd && yRamRd ##1 dualValid;
   endproperty
   a_dualBoth: assert property (p_dualBoth)
      else $error("dual read did not use both banks");

   property p_readPath;
      reqOp == dds_pkg::OP_READ |=> !xRamWr && !yRamWr ##1 rdValid && !dualValid;
   endproperty
   a_readPath: assert property (p_readPath)
      else $error("combined read did not return on the X read bus");

   property p_bitRev;
      reqOp == dds_pkg::OP_WRITE && reqBitRev && xAddr < Y_BASE
         |=> xRamWr && xRamAddr == $past(xRevAddr[ADDR_W-1:1]);
   endproperty
   a_bitRev: assert property (p_bitRev)
      else $error("X write missed the reversed address");

   property p_noRevRead;
      reqOp == dds_pkg::OP_READ && reqBitRev
         |=> (xRamRd ? xRamAddr : yRamAddr) == $past(xAddr[ADDR_W-1:1]);
   endproperty
   a_noRevRead: assert property (p_noRevRead)
      else $error("read address was reversed");

   property p_writeSpace;
      reqOp == dds_pkg::OP_WRITE && !reqBitRev && xAddr >= Y_BASE
         |=> yRamWr && !xRamWr;
   endproperty
   a_writeSpace: assert property (p_writeSpace)
      else $error("write above boundary missed the Y bank");

   property p_xModWrap;
      reqOp != dds_pkg::OP_IDLE && xModEn && xAddr == xModEnd |=> xNextPtr == $past(xModStart);
   endproperty
   a_xModWrap: assert property (p_xModWrap)
      else $error("X pointer did not wrap");

   property p_yModWrap;
      reqOp != dds_pkg::OP_IDLE && yModEn && yAddr == yModEnd |=> yNextPtr == $past(yModStart);
   endproperty
   a_yModWrap: assert property (p_yModWrap)
      else $error("Y pointer did not wrap");

   property p_wordLanes;
      reqOp == dds_pkg::OP_WRITE && !reqByte |=> (xRamBe | yRamBe) == `DDS_BE_WORD;
   endproperty
   a_wordLanes: assert property (p_wordLanes)
      else $error("word write lost a byte lane");

   property p_spaceErr;
      reqOp == dds_pkg::OP_DUAL && xAddr >= Y_BASE |=> spaceErr;
   endproperty
   a_spaceErr: assert property (p_spaceErr)
      else $error("X operand in Y space not flagged");

endmodule // dual_data_space_addressing
`default_nettype wire

// file: core/dds_params.svh
// constants for the dual data space address path
`ifndef DDS_PARAMS_SVH
`define DDS_PARAMS_SVH
`define DDS_ADDR_W 16
`define DDS_DATA_W 16
`define DDS_BYTE_W 8
`define DDS_REV_BITS 4
`define DDS_Y_BASE 16'h0800
`define DDS_BE_WORD 2'h3
`define DDS_BE_LO 2'h1
`define DDS_BE_HI 2'h2
`define DDS_BE_NONE 2'h0
`endif

// file: core/dds_pkg.sv
// types shared by the dual data space address path
package dds_pkg;
   typedef enum logic [1:0]
   {
      OP_IDLE = 2'h0,
      OP_READ = 2'h1,
      OP_WRITE = 2'h2,
      OP_DUAL = 2'h3
   } op_t;
endpackage

// file: tb/ram_model.sv
// behavioural data RAM bank facing one address path of the block
`timescale 1ns/1ps
`default_nettype none
module ram_model
(
   // clock
   input wire logic clk,
   // access from the block
   input wire logic rd,
   input wire logic wr,
   input wire logic [14:0] addr,
   input wire logic [1:0] be,
   input wire logic [15:0] wdata,
   // read data back to the block
   output logic [15:0] rdata
);
   // small array: only the low address bits decode, enough for the bench
   logic [15:0] mem [0:255];
   logic [15:0] lastQ;

   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = 16'(i) ^ 16'h5a5a;
      lastQ = 16'h0000;
   end

   always @(posedge clk)
   begin
      if (wr && be[0])
         mem[addr[7:0]][7:0] <= wdata[7:0];
      if (wr && be[1])
         mem[addr[7:0]][15:8] <= wdata[15:8];
      if (rd)
         lastQ <= mem[addr[7:0]];
   end

   // not selected: show the inverse of the last word so stale data never passes
   assign rdata = rd ? mem[addr[7:0]] : ~lastQ;
endmodule // ram_model
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the dual data space address path
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // ****************************
   // signals
   // ****************************
   logic coreClk, resetN, reqByte, reqBitRev, xModEn, yModEn;
   dds_pkg::op_t reqOp;
   logic [15:0] xAddr, yAddr, wrData, xStep, yStep, xModStart, xModEnd, yModStart, yModEnd;
   logic [14:0] xRamAddr, yRamAddr;
   logic xRamRd, xRamWr, yRamRd, yRamWr, rdValid, dualValid, spaceErr;
   logic [1:0] xRamBe, yRamBe;
   logic [15:0] xRamWdata, yRamWdata, xRamRdata, yRamRdata;
   logic [15:0] xReadData, yReadData, xNextPtr, yNextPtr;
   int nErrors = 0;
   int nCompared = 0;

   dual_data_space_addressing uut (.core_clk(coreClk), .reset_n(resetN), .reqOp(reqOp),
      .reqByte(reqByte), .reqBitRev(reqBitRev), .xAddr(xAddr), .yAddr(yAddr),
      .wrData(wrData), .xStep(xStep), .yStep(yStep), .xModEn(xModEn),
      .xModStart(xModStart), .xModEnd(xModEnd), .yModEn(yModEn), .yModStart(yModStart),
      .yModEnd(yModEnd), .xRamAddr(xRamAddr), .xRamRd(xRamRd), .xRamWr(xRamWr),
      .xRamBe(xRamBe), .xRamWdata(xRamWdata), .xRamRdata(xRamRdata), .yRamAddr(yRamAddr),
      .yRamRd(yRamRd), .yRamWr(yRamWr), .yRamBe(yRamBe), .yRamWdata(yRamWdata),
      .yRamRdata(yRamRdata), .xReadData(xReadData), .yReadData(yReadData),
      .rdValid(rdValid), .dualValid(dualValid), .xNextPtr(xNextPtr), .yNextPtr(yNextPtr),
      .spaceErr(spaceErr));
   ram_model xBank (.clk(coreClk), .rd(xRamRd), .wr(xRamWr), .addr(xRamAddr), .be(xRamBe),
      .wdata(xRamWdata), .rdata(xRamRdata));
   ram_model yBank (.clk(coreClk), .rd(yRamRd), .wr(yRamWr), .addr(yRamAddr), .be(yRamBe),
      .wdata(yRamWdata), .rdata(yRamRdata));

   initial
   begin
      coreClk = 1'b0;
      forever #50 coreClk = ~coreClk;
   end

   // ****************************
   // helpers
   // ****************************
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      nCompared++;
      if (seen !== exp)
      begin
         nErrors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   function automatic logic [3:0] rev4(input logic [3:0] v);
      return {v[0], v[1], v[2], v[3]};
   endfunction

   // one request cycle; returns at the falling edge of the strobe cycle
   task automatic doOp(input dds_pkg::op_t op, input logic byteAcc, input logic rev,
      input logic [15:0] xa, input logic [15:0] ya, input logic [15:0] wd);
      @(negedge coreClk);
      reqOp = op;
      reqByte = byteAcc;
      reqBitRev = rev;
      xAddr = xa;
      yAddr = ya;
      wrData = wd;
      @(negedge coreClk);
      reqOp = dds_pkg::OP_IDLE;
   endtask

   task automatic tallyAndFinish();
      $display("compared %0d mismatches %0d", nCompared, nErrors);
      if (nErrors == 0 && nCompared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ****************************
   // scenarios
   // ****************************
   task automatic testWordPath();
      doOp(dds_pkg::OP_WRITE, 1'b0, 1'b0, 16'h0010, 16'h0000, 16'h1234);
      check("xRamWr", xRamWr, 1'b1);
      check("xRamAddr", xRamAddr, 15'h0008);
      check("xRamBe", xRamBe, 2'h3);
      check("xRamWdata", xRamWdata, 16'h1234);
      doOp(dds_pkg::OP_WRITE, 1'b1, 1'b0, 16'h0031, 16'h0000, 16'h00ab);
      check("xRamBe byte", xRamBe, 2'h2);
      doOp(dds_pkg::OP_READ, 1'b0, 1'b0, 16'h0011, 16'h0000, 16'h0000);
      check("xRamRd", xRamRd, 1'b1);
      check("xRamAddr odd", xRamAddr, 15'h0008);
      @(negedge coreClk);
      check("rdValid", rdValid, 1'b1);
      check("xReadData", xReadData, 16'h1234);
      doOp(dds_pkg::OP_READ, 1'b1, 1'b0, 16'h0011, 16'h0000, 16'h0000);
      @(negedge coreClk);
      check("xReadData hi", xReadData, 16'h0012);
      doOp(dds_pkg::OP_READ, 1'b1, 1'b0, 16'h0010, 16'h0000, 16'h0000);
      @(negedge coreClk);
      check("xReadData lo", xReadData, 16'h0034);
      $display("done: word and byte path");
   endtask

   task automatic testCombined();
      doOp(dds_pkg::OP_WRITE, 1'b0, 1'b0, 16'h0820, 16'h0000, 16'hbeef);
      check("yRamWr", yRamWr, 1'b1);
      check("xRamWr", xRamWr, 1'b0);
      check("yRamAddr", yRamAddr, 15'h0410);
      check("yRamBe", yRamBe, 2'h3);
      check("yRamWdata", yRamWdata, 16'hbeef);
      doOp(dds_pkg::OP_READ, 1'b0, 1'b0, 16'h0820, 16'h0000, 16'h0000);
      check("yRamRd", yRamRd, 1'b1);
      @(negedge coreClk);
      check("xReadData comb", xReadData, 16'hbeef);
      $display("done: combined space");
   endtask

   task automatic testDual();
      doOp(dds_pkg::OP_DUAL, 1'b0, 1'b0, 16'h0010, 16'h0820, 16'h0000);
      check("dual xRamRd", xRamRd, 1'b1);
      check("dual yRamRd", yRamRd, 1'b1);
      check("spaceErr ok", spaceErr, 1'b0);
      @(negedge coreClk);
      check("dualValid", dualValid, 1'b1);
      check("dual x", xReadData, 16'h1234);
      check("dual y", yReadData, 16'hbeef);
      doOp(dds_pkg::OP_DUAL, 1'b0, 1'b0, 16'h0820, 16'h0010, 16'h0000);
      check("spaceErr bad", spaceErr, 1'b1);
      @(negedge coreClk);
      check("spaceErr pulse", spaceErr, 1'b0);
      check("dualValid bad", dualValid, 1'b1);
      $display("done: dual operand");
   endtask

   task automatic testBitRev();
      for (int i = 0; i < 16; i++)
      begin
         doOp(dds_pkg::OP_WRITE, 1'b0, 1'b1, 16'h0040 + 16'(i * 2), 16'h0000, 16'(i));
         check("rev xRamAddr", xRamAddr, {11'h002, rev4(4'(i))});
      end
      doOp(dds_pkg::OP_WRITE, 1'b0, 1'b1, 16'h0842, 16'h0000, 16'h0000);
      check("rev y ignored", yRamAddr, 15'h0421);
      doOp(dds_pkg::OP_READ, 1'b0, 1'b1, 16'h0042, 16'h0000, 16'h0000);
      check("rev read ignored", xRamAddr, 15'h0021);
      @(negedge coreClk);
      check("rev data", xReadData, 16'h0008);
      $display("done: bit reversal");
   endtask

   task automatic testModulo();
      @(negedge coreClk);
      xStep = 16'h0002;
      yStep = 16'h0002;
      xModEn = 1'b1;
      yModEn = 1'b1;
      doOp(dds_pkg::OP_DUAL, 1'b0, 1'b0, 16'h0106, 16'h0902, 16'h0000);
      check("xNextPtr wrap", xNextPtr, 16'h0100);
      check("yNextPtr step", yNextPtr, 16'h0904);
      doOp(dds_pkg::OP_DUAL, 1'b0, 1'b0, 16'h0102, 16'h0904, 16'h0000);
      check("xNextPtr step", xNextPtr, 16'h0104);
      check("yNextPtr wrap", yNextPtr, 16'h0900);
      @(negedge coreClk);
      check("xNextPtr hold", xNextPtr, 16'h0104);
      $display("done: modulo");
   endtask

   // ****************************
   // main sequence
   // ****************************
   initial
   begin
      resetN = 1'b0;
      reqOp = dds_pkg::OP_IDLE;
      {reqByte, reqBitRev, xModEn, yModEn} = 4'h0;
      {xAddr, yAddr, wrData, xStep, yStep} = '0;
      xModStart = 16'h0100;
      xModEnd = 16'h0106;
      yModStart = 16'h0900;
      yModEnd = 16'h0904;
      repeat (2) @(negedge coreClk);
      check("reset be", xRamBe, 2'h0);
      check("reset ptr", xNextPtr, 16'h0000);
      @(negedge coreClk);
      resetN = 1'b1;
      testWordPath();
      testCombined();
      testDual();
      testBitRev();
      testModulo();
      tallyAndFinish();
   end

   // hang guard
   initial
   begin
      #1_000_000;
      nErrors++;
      tallyAndFinish();
   end
endmodule // testbench
`default_nettype wire
